// *** adc_ctrl_pkg.sv ***
// Register map, field layout, codes and timing of the converter control block
`default_nettype none
package adc_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_STATUS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_RESULT_HIGH        = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW         = 8'h0C;
  localparam logic [7:0] OFF_COMPARE_VALUE_HIGH = 8'h10;
  localparam logic [7:0] OFF_COMPARE_VALUE_LOW  = 8'h14;
  localparam logic [7:0] OFF_CONVERTER_CONFIG   = 8'h18;
  localparam logic [7:0] OFF_PIN_SEL_LOW        = 8'h1C;
  localparam logic [7:0] OFF_PIN_SEL_MID        = 8'h20;
  localparam logic [7:0] OFF_PIN_SEL_HIGH       = 8'h24;

  // status_control_one fields
  localparam int SC1_DONE_BIT = 7;
  localparam int SC1_IE_BIT   = 6;
  localparam int SC1_CONT_BIT = 5;
  localparam int SC1_CH_LSB   = 0;
  localparam int CH_W         = 5;
  localparam logic [4:0] CH_ALL_ONES = 5'h1F;

  // status_control_two fields
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_HWEN_BIT   = 6;
  localparam int SC2_CMPEN_BIT  = 5;
  localparam int SC2_CMPGT_BIT  = 4;
  localparam logic [7:0] SC2_WR_MASK = 8'h70;

  // converter_config fields
  localparam int CFG_DIV_LSB  = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_SRC_LSB  = 0;

  // Mode and clock source codes
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] SRC_BUS    = 2'h0;
  localparam logic [1:0] SRC_HALF   = 2'h1;
  localparam logic [1:0] SRC_ALT    = 2'h2;
  localparam logic [1:0] SRC_ASYNC  = 2'h3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Conversion length in converter clock cycles
  localparam logic [4:0] CONV_TICKS_8BIT  = 5'h14;
  localparam logic [4:0] CONV_TICKS_10BIT = 5'h17;

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} conv_state_t;

endpackage
`default_nettype wire

// *** adc_ctrl.sv ***
// Converter control: APB registers, pin control, clocking, triggers and results
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (RULE_01) Analog-selected pin has its output driver forced to high impedance.
// (RULE_02) Analog-selected pin has input buffer off; port reads give zero.
// (RULE_03) Analog-selected pin has its pullup switched off.
// (RULE_04) Mid pin register bits 7..0 select channels 15..8; one removes port control.
// (RULE_05) High pin register bits 7..0 select channels 23..16; one removes port control.
// (RULE_06) Converter disabled in reset and while channel select is all ones; a trigger edge in the cycle of the all-ones write still starts it.
// (RULE_07) Between conversions the converter idles in its lowest power state.
// (RULE_08) Ten-bit mode rounds an 11-bit result to 10 bits over both result registers.
// (RULE_09) Eight-bit mode rounds a 9-bit result to 8 bits in low result only.
// (RULE_10) After storing a result set done flag; interrupt if enabled.
// (RULE_11) Compare enable checks each result against compare registers in all modes.
// (RULE_12) Clock source: bus, bus halved, alternate, asynchronous; bus after reset.
// (RULE_13) Selected asynchronous clock keeps running through wait and stop.
// (RULE_14) Selected clock divided by 1, 2, 4 or 8 forms converter clock.
// (RULE_15) With trigger enabled, rising trigger edge starts a conversion in any mode.
// (RULE_16) Trigger edge during a conversion is ignored.
// (RULE_17) Continuous hardware mode observes only the first launching edge.
// (RULE_18) Mode field selects 10-bit or 8-bit resolution.
// (RULE_19) Software mode: write to first status register starts unless channel all ones.
// (RULE_20) Continuous mode: each result transfer starts the next, until aborted.
// (RULE_21) Continuous runs start on register write or first hardware trigger.
// (RULE_22) Mode code 00 is 8-bit, 10 is 10-bit; others reserved.
// (RULE_23) Source codes 00 bus, 01 bus halved, 10 alternate, 11 asynchronous.
// (RULE_24) Divide codes 00..11 give ratios 1, 2, 4, 8.
// (RULE_25) Writes to second status, config or compare registers abort conversions.
// (RULE_26) All pin control registers reset to zero.
module adc_ctrl #(
  parameter int unsigned ADDR_W    = 8,
  parameter int unsigned ASYNC_DIV = 8
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hw_trigger_input,
  input  wire logic              alternate_clock,
  input  wire logic [10:0]       sar_value,
  input  wire logic [15:0]       port_pin_in,
  output logic      [15:0]       port_read_data,
  output logic      [15:0]       pin_output_hiz,
  output logic      [15:0]       pin_input_disable,
  output logic      [15:0]       pin_pullup_disable,
  output logic      [4:0]        converter_channel,
  output logic                   converter_power,
  output logic                   async_clock_run,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W must be at least 6");
  end
  if (ASYNC_DIV < 2 || ASYNC_DIV > 256) begin : g_bad_async
    $error("ASYNC_DIV must be within 2 to 256");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    adc_ctrl_pkg::conv_state_t state;
    logic [7:0]  sc1;
    logic [7:0]  sc2;
    logic [7:0]  cfg;
    logic [1:0]  cvh;
    logic [7:0]  cvl;
    logic [1:0]  rh;
    logic [7:0]  rl;
    logic [7:0]  sel_low;
    logic [7:0]  sel_mid;
    logic [7:0]  sel_high;
    logic [2:0]  hw_sync;
    logic [2:0]  alt_sync;
    logic [15:0] pin_sync1;
    logic [15:0] pin_sync2;
    logic [15:0] port_rd;
    logic [7:0]  async_cnt;
    logic        half_tog;
    logic [2:0]  div_cnt;
    logic [4:0]  tick_cnt;
    logic        cont_run;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        async_run;
  } state_t;

  state_t state_reg;
  state_t state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = a == ADDR_W'(off);
  endfunction

  function automatic logic [9:0] round_result(input logic [10:0] raw, input logic ten);
    logic [11:0] s11;
    logic [9:0]  s9;
    s11 = {1'h0, raw} + 12'h001;
    s9  = {1'h0, raw[10:2]} + 10'h001;
    if (ten) begin
      round_result = s11[11] ? 10'h3FF : s11[10:1];
    end else begin
      round_result = s9[9] ? 10'h0FF : {2'h0, s9[8:1]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic        hw_edge;
  logic        src_tick;
  logic [2:0]  div_mask;
  logic        conv_tick;
  logic        ten_bit;
  logic [4:0]  conv_len;
  logic        finish;
  logic [9:0]  rounded;
  logic [9:0]  cmp_val;
  logic        cmp_ok;
  logic [9:0]  stored;
  logic        done_set;
  logic        done_clr;
  logic        sw_start;
  logic        hw_start;
  logic        abort;
  logic        restart;

  always_comb begin
    state_next = state_reg;
    acc    = psel & penable & state_reg.pready;
    wr     = acc & pwrite;
    rd     = acc & ~pwrite;
    mapped = 1'h0;
    rd_byte = 8'h00;
    unique case (1'h1)
      hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE): rd_byte = state_reg.sc1;
      hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_TWO): begin
        rd_byte = state_reg.sc2;
        rd_byte[adc_ctrl_pkg::SC2_ACTIVE_BIT] = state_reg.state == adc_ctrl_pkg::ST_CONV;
      end
      hit(paddr, adc_ctrl_pkg::OFF_RESULT_HIGH):        rd_byte = {6'h00, state_reg.rh};
      hit(paddr, adc_ctrl_pkg::OFF_RESULT_LOW):         rd_byte = state_reg.rl;
      hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_HIGH): rd_byte = {6'h00, state_reg.cvh};
      hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_LOW):  rd_byte = state_reg.cvl;
      hit(paddr, adc_ctrl_pkg::OFF_CONVERTER_CONFIG):   rd_byte = state_reg.cfg;
      hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_LOW):        rd_byte = state_reg.sel_low;
      hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_MID):        rd_byte = state_reg.sel_mid;
      hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_HIGH):       rd_byte = state_reg.sel_high;
      default:                                          rd_byte = 8'h00;
    endcase
    mapped = hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE)
           | hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_TWO)
           | hit(paddr, adc_ctrl_pkg::OFF_RESULT_HIGH)
           | hit(paddr, adc_ctrl_pkg::OFF_RESULT_LOW)
           | hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_HIGH)
           | hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_LOW)
           | hit(paddr, adc_ctrl_pkg::OFF_CONVERTER_CONFIG)
           | hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_LOW)
           | hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_MID)
           | hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_HIGH);

    // APB answer one cycle into the access phase
    state_next.pready  = psel & penable & ~state_reg.pready;
    state_next.pslverr = psel & penable & ~state_reg.pready & ~mapped;
    state_next.prdata  = (psel & penable & ~state_reg.pready & ~pwrite) ? {24'h000000, rd_byte}
                                                                       : 32'h00000000;

    // Synchronisers for pins and the alternate clock
    state_next.hw_sync   = {state_reg.hw_sync[1:0], hw_trigger_input};
    state_next.alt_sync  = {state_reg.alt_sync[1:0], alternate_clock};
    state_next.pin_sync1 = port_pin_in;
    state_next.pin_sync2 = state_reg.pin_sync1;
    hw_edge = state_reg.hw_sync[1] & ~state_reg.hw_sync[2];

    // Clock source select and divide
    state_next.half_tog  = ~state_reg.half_tog;
    state_next.async_cnt = (state_reg.async_cnt == 8'(ASYNC_DIV - 1)) ? 8'h00
                         : state_reg.async_cnt + 8'h01;
    unique case (state_reg.cfg[adc_ctrl_pkg::CFG_SRC_LSB +: 2]) // see (RULE_12) see (RULE_23)
      adc_ctrl_pkg::SRC_BUS:   src_tick = 1'h1;
      adc_ctrl_pkg::SRC_HALF:  src_tick = state_reg.half_tog;
      adc_ctrl_pkg::SRC_ALT:   src_tick = state_reg.alt_sync[1] & ~state_reg.alt_sync[2];
      adc_ctrl_pkg::SRC_ASYNC: src_tick = state_reg.async_cnt == 8'h00;
    endcase
    unique case (state_reg.cfg[adc_ctrl_pkg::CFG_DIV_LSB +: 2]) // see (RULE_14) see (RULE_24)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      2'h3: div_mask = 3'h7;
    endcase
    conv_tick = src_tick & ((state_reg.div_cnt & div_mask) == div_mask);
    if (src_tick) begin
      state_next.div_cnt = state_reg.div_cnt + 3'h1;
    end

    // Conversion length and completion
    ten_bit  = state_reg.cfg[adc_ctrl_pkg::CFG_MODE_LSB +: 2] // see (RULE_18) see (RULE_22)
               == adc_ctrl_pkg::MODE_10BIT;
    conv_len = ten_bit ? adc_ctrl_pkg::CONV_TICKS_10BIT : adc_ctrl_pkg::CONV_TICKS_8BIT;
    finish   = (state_reg.state == adc_ctrl_pkg::ST_CONV) & conv_tick
             & (state_reg.tick_cnt == conv_len - 5'h01);
    if ((state_reg.state == adc_ctrl_pkg::ST_CONV) && conv_tick) begin
      state_next.tick_cnt = state_reg.tick_cnt + 5'h01;
    end
    rounded = round_result(sar_value, ten_bit); // see (RULE_08) see (RULE_09)
    cmp_val = ten_bit ? {state_reg.cvh, state_reg.cvl} : {2'h0, state_reg.cvl};
    cmp_ok  = state_reg.sc2[adc_ctrl_pkg::SC2_CMPGT_BIT] ? (rounded >= cmp_val)
                                                        : (rounded < cmp_val);
    if (!state_reg.sc2[adc_ctrl_pkg::SC2_CMPEN_BIT]) begin
      cmp_ok = 1'h1;
      stored = rounded;
    end else begin
      stored = rounded - cmp_val; // see (RULE_11)
    end
    if (!ten_bit) begin
      stored[9:8] = 2'h0;
    end
    done_set = finish & cmp_ok;
    if (done_set) begin
      state_next.rh = stored[9:8]; // see (RULE_08) see (RULE_09)
      state_next.rl = stored[7:0];
    end
    restart = 1'h0;
    if (finish) begin
      if (state_reg.sc1[adc_ctrl_pkg::SC1_CONT_BIT]) begin
        restart = 1'h1; // see (RULE_20)
      end else begin
        state_next.state    = adc_ctrl_pkg::ST_IDLE; // see (RULE_07)
        state_next.cont_run = 1'h0;
      end
    end

    // Register writes, starts and aborts
    sw_start = wr & hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE)
             & (pwdata[adc_ctrl_pkg::SC1_CH_LSB +: adc_ctrl_pkg::CH_W] != adc_ctrl_pkg::CH_ALL_ONES)
             & ~state_reg.sc2[adc_ctrl_pkg::SC2_HWEN_BIT]; // see (RULE_19) see (RULE_06)
    hw_start = state_reg.sc2[adc_ctrl_pkg::SC2_HWEN_BIT] & hw_edge
             & (state_reg.state == adc_ctrl_pkg::ST_IDLE) & ~state_reg.cont_run
             & (state_reg.sc1[adc_ctrl_pkg::SC1_CH_LSB +: adc_ctrl_pkg::CH_W]
                != adc_ctrl_pkg::CH_ALL_ONES); // see (RULE_15) see (RULE_16) see (RULE_17)
    abort = wr & (hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE)
                | hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_TWO)
                | hit(paddr, adc_ctrl_pkg::OFF_CONVERTER_CONFIG)
                | hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_HIGH)
                | hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_LOW)); // see (RULE_25)
    done_clr = (wr & hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE))
             | (rd & hit(paddr, adc_ctrl_pkg::OFF_RESULT_LOW));
    if (wr) begin
      if (hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE)) begin
        state_next.sc1[6:0] = pwdata[6:0];
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_TWO)) begin
        state_next.sc2 = pwdata[7:0] & adc_ctrl_pkg::SC2_WR_MASK;
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_CONVERTER_CONFIG)) begin
        state_next.cfg = pwdata[7:0];
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_HIGH)) begin
        state_next.cvh = pwdata[1:0];
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_COMPARE_VALUE_LOW)) begin
        state_next.cvl = pwdata[7:0];
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_LOW)) begin
        state_next.sel_low = pwdata[7:0];
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_MID)) begin
        state_next.sel_mid = pwdata[7:0]; // see (RULE_04)
      end
      if (hit(paddr, adc_ctrl_pkg::OFF_PIN_SEL_HIGH)) begin
        state_next.sel_high = pwdata[7:0]; // see (RULE_05)
      end
    end
    // Set wins over clear
    state_next.sc1[adc_ctrl_pkg::SC1_DONE_BIT] =
      done_set | (state_reg.sc1[adc_ctrl_pkg::SC1_DONE_BIT] & ~done_clr); // see (RULE_10)

    if (abort) begin
      state_next.state    = adc_ctrl_pkg::ST_IDLE;
      state_next.cont_run = 1'h0;
    end
    if (sw_start || hw_start || (restart && !abort)) begin
      state_next.state    = adc_ctrl_pkg::ST_CONV;
      state_next.tick_cnt = 5'h00;
      state_next.div_cnt  = 3'h0;
      if (sw_start || hw_start) begin
        state_next.cont_run = state_next.sc1[adc_ctrl_pkg::SC1_CONT_BIT]; // see (RULE_21)
      end
    end

    // Pin control and port read gating
    state_next.port_rd = state_reg.pin_sync2
                       & ~{state_next.sel_high, state_next.sel_mid}; // see (RULE_02)
    state_next.irq = state_next.sc1[adc_ctrl_pkg::SC1_DONE_BIT]
                   & state_next.sc1[adc_ctrl_pkg::SC1_IE_BIT]; // see (RULE_10)
    state_next.async_run = (state_next.state == adc_ctrl_pkg::ST_CONV)
                         & (state_next.cfg[adc_ctrl_pkg::CFG_SRC_LSB +: 2]
                            == adc_ctrl_pkg::SRC_ASYNC); // see (RULE_13)
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= '0; // see (RULE_26)
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata             = state_reg.prdata;
  assign pready             = state_reg.pready;
  assign pslverr            = state_reg.pslverr;
  assign port_read_data     = state_reg.port_rd;
  assign pin_output_hiz     = {state_reg.sel_high, state_reg.sel_mid}; // see (RULE_01)
  assign pin_input_disable  = {state_reg.sel_high, state_reg.sel_mid}; // see (RULE_02)
  assign pin_pullup_disable = {state_reg.sel_high, state_reg.sel_mid}; // see (RULE_03)
  assign converter_channel  = state_reg.sc1[adc_ctrl_pkg::SC1_CH_LSB +: adc_ctrl_pkg::CH_W];
  assign converter_power    = state_reg.state == adc_ctrl_pkg::ST_CONV; // see (RULE_07)
  assign async_clock_run    = state_reg.async_run; // see (RULE_13)
  assign irq                = state_reg.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wr(logic [7:0] off);
    psel && penable && pready && pwrite && hit(paddr, off);
  endsequence

  sequence s_setup;
    psel && penable && !pready;
  endsequence

  a_pin_sel_mid: assert property (s_wr(adc_ctrl_pkg::OFF_PIN_SEL_MID) |=> // see (RULE_04)
    pin_output_hiz[7:0] == $past(pwdata[7:0]) && pin_pullup_disable[7:0] == $past(pwdata[7:0]))
    else $error("mid pin select not applied");
  a_pin_sel_high: assert property (s_wr(adc_ctrl_pkg::OFF_PIN_SEL_HIGH) |=> // see (RULE_05)
    pin_input_disable[15:8] == $past(pwdata[7:0]))
    else $error("high pin select not applied");
  a_port_read_zero: assert property ((port_read_data & pin_input_disable) == '0) // see (RULE_02)
    else $error("disabled pin reads nonzero");
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
  a_disabled_idle: assert property (!converter_power && converter_channel == 5'h1F // see (RULE_06)
    && !(psel && penable && pready && pwrite && hit(paddr, adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE))
    |=> !converter_power)
    else $error("converter started with channel off");
  a_sw_start: assert property (s_wr(adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE) // see (RULE_19)
    ##0 (pwdata[4:0] != 5'h1F && !state_reg.sc2[adc_ctrl_pkg::SC2_HWEN_BIT])
    |=> converter_power && state_reg.tick_cnt == 5'h00)
    else $error("software start missing");
  a_cfg_abort: assert property (s_wr(adc_ctrl_pkg::OFF_CONVERTER_CONFIG) // see (RULE_25)
    |=> !converter_power)
    else $error("config write did not abort");
  a_done_store: assert property (done_set && !done_clr |=> // see (RULE_10)
    state_reg.sc1[adc_ctrl_pkg::SC1_DONE_BIT] && state_reg.rl == $past(stored[7:0]))
    else $error("done flag or result not stored");
  a_irq_gate: assert property ($rose(state_reg.sc1[adc_ctrl_pkg::SC1_DONE_BIT]) // see (RULE_10)
    && state_reg.sc1[adc_ctrl_pkg::SC1_IE_BIT] |-> irq)
    else $error("interrupt not raised");
  a_hw_ignored: assert property (converter_power && hw_edge && !finish && !abort // see (RULE_16)
    |=> converter_power && state_reg.tick_cnt >= $past(state_reg.tick_cnt))
    else $error("trigger restarted running conversion");
  a_cont_next: assert property (finish && state_reg.sc1[adc_ctrl_pkg::SC1_CONT_BIT] // see (RULE_20)
    && !abort |=> converter_power && state_reg.tick_cnt == 5'h00)
    else $error("continuous conversion not restarted");

endmodule
`default_nettype wire

// *** adc_far_side.sv ***
// Far side model: port pins, trigger source, analog core, alternate clock
`timescale 1ns/1ps
`default_nettype none
module adc_far_side #(
  parameter logic [15:0] PINS = 16'h5AF0
) (
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [10:0] level,
  output logic             hw_trigger_input,
  output logic             alternate_clock,
  output logic [10:0]      sar_value,
  output logic [15:0]      port_pin_in
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    {hw_trigger_input, alternate_clock, sar_value} = 13'h0000;
  end
  // Alternate clock runs at a quarter of the bus clock
  always @(posedge clk) begin
    div_q            <= div_q + 2'h1;
    alternate_clock  <= div_q[1];
    hw_trigger_input <= fire;
    sar_value        <= level;
  end
  assign port_pin_in = PINS;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] SC1 = adc_ctrl_pkg::OFF_STATUS_CONTROL_ONE;
  localparam logic [7:0] SC2 = adc_ctrl_pkg::OFF_STATUS_CONTROL_TWO;
  localparam logic [7:0] RH  = adc_ctrl_pkg::OFF_RESULT_HIGH;
  localparam logic [7:0] RL  = adc_ctrl_pkg::OFF_RESULT_LOW;
  localparam logic [7:0] CFG = adc_ctrl_pkg::OFF_CONVERTER_CONFIG;
  localparam logic [7:0] MID = adc_ctrl_pkg::OFF_PIN_SEL_MID;
  localparam logic [7:0] HI  = adc_ctrl_pkg::OFF_PIN_SEL_HIGH;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, err, fire = 1'b0, trig, altc, irq, pwr, arun;
  logic [10:0] level = 11'h2A5, sar;
  logic [15:0] pins, prd, hiz, idis, pdis;
  logic [4:0]  chan;
  int          errors = 0, checked = 0, n;
  initial forever #2.5 clk = ~clk;
  adc_far_side u_far (.clk(clk), .fire(fire), .level(level), .hw_trigger_input(trig),
    .alternate_clock(altc), .sar_value(sar), .port_pin_in(pins));
  adc_ctrl u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trigger_input(trig), .alternate_clock(altc), .sar_value(sar), .port_pin_in(pins),
    .port_read_data(prd), .pin_output_hiz(hiz), .pin_input_disable(idis),
    .pin_pullup_disable(pdis), .converter_channel(chan), .converter_power(pwr),
    .async_clock_run(arun), .irq(irq));
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, MID, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, HI, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, CFG, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, MID, 8'hA5);
    apb(1'b1, HI, 8'h3C);
    apb(1'b0, HI, 8'h00);
    chk(rd, 32'h3C);
    repeat (4) @(posedge clk);
    chk({16'h0, hiz}, 32'h3CA5);
    chk({16'h0, idis}, 32'h3CA5);
    chk({16'h0, pdis}, 32'h3CA5);
    chk({16'h0, prd}, 32'h4250);
    apb(1'b0, 8'h28, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("test pins done");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, CFG, {1'b0, r[1:0], 5'h08});
      apb(1'b1, SC1, 8'h43);
      chk({31'h0, pwr}, 32'h1);
      chk({27'h0, chan}, 32'h3);
      wait_irq(400);
      chk({31'h0, (n >= (22 << r) && n <= (24 << r) + 6)}, 32'h1);
      chk({31'h0, pwr}, 32'h0);
      apb(1'b0, RH, 8'h00);
      chk(rd, 32'h1);
      apb(1'b0, RL, 8'h00);
      chk(rd, 32'h53);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test divider done");
    apb(1'b1, CFG, 8'h01);
    apb(1'b1, SC1, 8'h43);
    wait_irq(400);
    chk({31'h0, (n >= 37 && n <= 44)}, 32'h1);
    apb(1'b0, RH, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, CFG, 8'h03);
    apb(1'b1, SC1, 8'h43);
    chk({31'h0, arun}, 32'h1);
    wait_irq(2000);
    chk({31'h0, arun}, 32'h0);
    apb(1'b1, CFG, 8'h02);
    apb(1'b1, SC1, 8'h43);
    wait_irq(400);
    chk({31'h0, (n >= 76 && n <= 90)}, 32'h1);
    apb(1'b1, SC1, 8'h5F);
    repeat (40) @(posedge clk);
    chk({30'h0, pwr, irq}, 32'h0);
    $display("test sources done");
    apb(1'b1, CFG, 8'h00);
    apb(1'b1, SC2, 8'h40);
    apb(1'b1, SC1, 8'h43);
    fire <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, pwr}, 32'h1);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    fire <= 1'b1;
    wait_irq(400);
    chk({31'h0, (n >= 14 && n <= 18)}, 32'h1);
    apb(1'b0, RL, 8'h00);
    repeat (40) @(posedge clk);
    chk({30'h0, pwr, irq}, 32'h0);
    fire <= 1'b0;
    apb(1'b1, SC1, 8'h63);
    repeat (3) @(posedge clk);
    fire <= 1'b1;
    wait_irq(400);
    apb(1'b0, RL, 8'h00);
    wait_irq(100);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, SC2, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, pwr}, 32'h0);
    fire <= 1'b0;
    $display("test triggers done");
    apb(1'b1, CFG, 8'h08);
    apb(1'b1, adc_ctrl_pkg::OFF_COMPARE_VALUE_LOW, 8'h10);
    apb(1'b1, SC2, 8'h30);
    apb(1'b1, SC1, 8'h43);
    wait_irq(400);
    apb(1'b0, RL, 8'h00);
    chk(rd, 32'h43);
    apb(1'b1, adc_ctrl_pkg::OFF_COMPARE_VALUE_HIGH, 8'h03);
    apb(1'b1, SC1, 8'h43);
    wait_irq(100);
    chk({31'h0, irq}, 32'h0);
    $display("test compare done");
    end_of_test();
  end
endmodule
`default_nettype wire
